// *** t2crc_pkg.sv ***
// package for the timer 2 capture/reload counter
package t2crc_pkg;
    // ------------------------------------------------------------
    // register byte addresses
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_CONTROL  = 8'h00;
    localparam logic [7:0] OFF_MODE     = 8'h04;
    localparam logic [7:0] OFF_COUNT_LO = 8'h08;
    localparam logic [7:0] OFF_COUNT_HI = 8'h0C;
    localparam logic [7:0] OFF_RELOAD_LO = 8'h10;
    localparam logic [7:0] OFF_RELOAD_HI = 8'h14;
    localparam logic [7:0] OFF_IRQ_EN   = 8'h18;
    // ------------------------------------------------------------
    // control and mode field positions
    // ------------------------------------------------------------
    localparam int BIT_OVF    = 7;
    localparam int BIT_EXTF   = 6;
    localparam int BIT_RXCLK  = 5;
    localparam int BIT_TXCLK  = 4;
    localparam int BIT_EXEN   = 3;
    localparam int BIT_RUN    = 2;
    localparam int BIT_CNTSEL = 1;
    localparam int BIT_CAPSEL = 0;
    localparam int BIT_DOWN_COUNT_ENABLE   = 0;
    // ------------------------------------------------------------
    // reset values and timing
    // ------------------------------------------------------------
    localparam logic [7:0]  RST_CONTROL = 8'h00;
    localparam logic [15:0] RST_COUNT   = 16'h0000;
    localparam logic [15:0] CNT_MAX     = 16'hFFFF;
    localparam logic [3:0]  OSC_DIV_TMR = 4'hC;    // oscillator periods per timer tick
    localparam logic [3:0]  OSC_DIV_BAUD = 4'h2;   // oscillator periods per baud tick
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage : t2crc_pkg

// *** t2crc_timer.sv ***
// timer 2 capture/reload counter with an axi4-lite register slave
// Functional notes
// - counter_select 0 counts every twelve clocks (every second in baud mode), 1 counts count_input falling edges
// - run_bit on selects reload, capture or baud mode from the select bits
// - capture mode without external_enable free runs and sets overflow_flag on wrap
// - capture mode with external_enable copies count to reload bytes on trigger fall
// - capture mode never reloads the count; counting continues through captures
// - overflow_flag and external_flag (outside up/down mode) share one interrupt when enabled
// - down_count_enable resets 0; when 1 in reload mode trigger level picks direction
// - up-only reload mode overflows past FFFF, sets overflow_flag, loads reload value
// - up-only reload mode trigger fall with external_enable reloads and sets external_flag
// - up/down mode with trigger high counts up, overflow sets flag and reloads
// - up/down mode trigger low counts down, underflow at reload value loads FFFF
// - up/down mode toggles external_flag on each wrap; no interrupt from it
// - external_flag set when trigger fall causes capture or reload with enable
// - trigger edges act only with external_enable and outside up/down mode
// - tx/rx clock selects route this timer's overflow pulses to the serial port
// - baud mode with counter_select 0 counts every second clock and reloads on each rollover
// - baud rollover sets no overflow_flag; trigger fall sets external_flag only
`timescale 1ns/100ps
module t2crc_timer
    import t2crc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address and data
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // external pins
    input  wire logic        count_input,
    input  wire logic        trigger_input,
    // serial baud pulses and interrupt
    output logic             tx_baud_tick,
    output logic             rx_baud_tick,
    output logic             timer_irq
);
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] byte_word(input logic [7:0] b);
        byte_word = {24'h0000_00, b};
    endfunction : byte_word

    function automatic logic wr_low(input logic [3:0] strb);
        wr_low = strb[0];
    endfunction : wr_low

    // ------------------------------------------------------------
    // pin synchronisers and edge detect
    // ------------------------------------------------------------
    logic [2:0] trig_sync_q, trig_sync_d;
    logic [2:0] cnt_sync_q, cnt_sync_d;
    logic       trig_fall, cnt_fall, trig_level;

    // two stages, third holds previous sample
    always_comb begin
        trig_sync_d = {trig_sync_q[1:0], trigger_input};
        cnt_sync_d  = {cnt_sync_q[1:0], count_input};
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trig_sync_q <= 3'h7;
            cnt_sync_q  <= 3'h7;
        end else begin
            trig_sync_q <= trig_sync_d;
            cnt_sync_q  <= cnt_sync_d;
        end
    end

    assign trig_fall  = trig_sync_q[2] & ~trig_sync_q[1];
    assign cnt_fall   = cnt_sync_q[2] & ~cnt_sync_q[1];
    assign trig_level = trig_sync_q[1];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]  ctrl_q, ctrl_d;
    logic        down_count_enable_q, down_count_enable_d;
    logic        irq_en_q, irq_en_d;
    logic [15:0] count_q, count_d;
    logic [15:0] reload_q, reload_d;
    logic [3:0]  pre_q, pre_d;
    logic        tx_tick_q, tx_tick_d, rx_tick_q, rx_tick_d, irq_q, irq_d;

    // bus write strobes
    logic        wr_fire;
    logic [7:0]  wr_addr;
    logic [7:0]  wr_byte;

    // mode decode
    logic baud_mode, cap_mode, rel_mode, updown, tick, ext_evt, wrap_up, wrap_dn;

    always_comb begin
        baud_mode = ctrl_q[BIT_RXCLK] | ctrl_q[BIT_TXCLK];
        cap_mode  = ~baud_mode & ctrl_q[BIT_CAPSEL];
        rel_mode  = ~baud_mode & ~ctrl_q[BIT_CAPSEL];
        updown    = rel_mode & down_count_enable_q;
        ext_evt   = trig_fall & ctrl_q[BIT_EXEN];
        if (ctrl_q[BIT_CNTSEL])
            tick = cnt_fall;
        else if (baud_mode)
            tick = (pre_q == OSC_DIV_BAUD - 4'h1);
        else
            tick = (pre_q == OSC_DIV_TMR - 4'h1);
        tick    = tick & ctrl_q[BIT_RUN];
        wrap_dn = updown & ~trig_level & (count_q == reload_q);
        wrap_up = (~updown | trig_level) & (count_q == CNT_MAX);
    end

    // counter, flags and control next state
    always_comb begin
        ctrl_d    = ctrl_q;
        down_count_enable_d    = down_count_enable_q;
        irq_en_d  = irq_en_q;
        count_d   = count_q;
        reload_d  = reload_q;
        pre_d     = pre_q;
        tx_tick_d = 1'b0;
        rx_tick_d = 1'b0;
        // software writes first so hardware events win
        if (wr_fire) begin
            unique case (wr_addr)
                OFF_CONTROL:   ctrl_d = wr_byte;
                OFF_MODE:      down_count_enable_d = wr_byte[BIT_DOWN_COUNT_ENABLE];
                OFF_COUNT_LO:  count_d[7:0] = wr_byte;
                OFF_COUNT_HI:  count_d[15:8] = wr_byte;
                OFF_RELOAD_LO: reload_d[7:0] = wr_byte;
                OFF_RELOAD_HI: reload_d[15:8] = wr_byte;
                OFF_IRQ_EN:    irq_en_d = wr_byte[0];
                default:       ;
            endcase
        end
        // prescaler free runs while the timer runs, on either clock source
        if (!ctrl_q[BIT_RUN] || tick)
            pre_d = 4'h0;
        else
            pre_d = pre_q + 4'h1;
        if (tick) begin
            if (updown && !trig_level) begin
                if (wrap_dn) begin
                    count_d = CNT_MAX;
                    ctrl_d[BIT_OVF]  = 1'b1;
                    ctrl_d[BIT_EXTF] = ~ctrl_q[BIT_EXTF];
                end else
                    count_d = count_q - 16'h0001;
            end else if (wrap_up) begin
                if (cap_mode)
                    count_d = 16'h0000;
                else
                    count_d = reload_q;
                if (baud_mode) begin
                    tx_tick_d = ctrl_q[BIT_TXCLK];
                    rx_tick_d = ctrl_q[BIT_RXCLK];
                end else
                    ctrl_d[BIT_OVF] = 1'b1;
                if (updown)
                    ctrl_d[BIT_EXTF] = ~ctrl_q[BIT_EXTF];
            end else
                count_d = count_q + 16'h0001;
        end
        // trigger events outside up/down mode
        if (ext_evt && !updown) begin
            ctrl_d[BIT_EXTF] = 1'b1;
            if (cap_mode)
                reload_d = count_q;
            else if (rel_mode)
                count_d = reload_q;
        end
    end

    assign irq_d = irq_en_q & (ctrl_d[BIT_OVF] | (ctrl_d[BIT_EXTF] & ~updown));

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q    <= RST_CONTROL;
            down_count_enable_q    <= 1'b0;
            irq_en_q  <= 1'b0;
            count_q   <= RST_COUNT;
            reload_q  <= RST_COUNT;
            pre_q     <= 4'h0;
            tx_tick_q <= 1'b0;
            rx_tick_q <= 1'b0;
            irq_q     <= 1'b0;
        end else begin
            ctrl_q    <= ctrl_d;
            down_count_enable_q    <= down_count_enable_d;
            irq_en_q  <= irq_en_d;
            count_q   <= count_d;
            reload_q  <= reload_d;
            pre_q     <= pre_d;
            tx_tick_q <= tx_tick_d;
            rx_tick_q <= rx_tick_d;
            irq_q     <= irq_d;
        end
    end

    assign tx_baud_tick = tx_tick_q;
    assign rx_baud_tick = rx_tick_q;
    assign timer_irq    = irq_q;

    // ------------------------------------------------------------
    // axi4-lite write channel
    // ------------------------------------------------------------
    logic       aw_got_q, aw_got_d, w_got_q, w_got_d, bvalid_q, bvalid_d;
    logic [7:0] aw_q, aw_d, wd_q, wd_d;
    logic       wen_q, wen_d;
    logic [1:0] bresp_q, bresp_d;

    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        aw_d     = aw_q;
        wd_d     = wd_q;
        wen_d    = wen_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        if (s_axi_awvalid && !aw_got_q) begin
            aw_got_d = 1'b1;
            aw_d     = s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_got_q) begin
            w_got_d = 1'b1;
            wd_d    = s_axi_wdata[7:0];
            wen_d   = wr_low(s_axi_wstrb);
        end
        if (aw_got_q && w_got_q && !bvalid_q) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = (aw_q <= OFF_IRQ_EN && aw_q[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
        end else if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
    end

    assign wr_fire = aw_got_q & w_got_q & ~bvalid_q & wen_q;
    assign wr_addr = aw_q;
    assign wr_byte = wd_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q <= 1'b0;
            w_got_q  <= 1'b0;
            aw_q     <= 8'h00;
            wd_q     <= 8'h00;
            wen_q    <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else begin
            aw_got_q <= aw_got_d;
            w_got_q  <= w_got_d;
            aw_q     <= aw_d;
            wd_q     <= wd_d;
            wen_q    <= wen_d;
            bvalid_q <= bvalid_d;
            bresp_q  <= bresp_d;
        end
    end

    assign s_axi_awready = ~aw_got_q;
    assign s_axi_wready  = ~w_got_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;

    // ------------------------------------------------------------
    // axi4-lite read channel
    // ------------------------------------------------------------
    logic        rvalid_q, rvalid_d;
    logic [31:0] rdata_q, rdata_d;
    logic [1:0]  rresp_q, rresp_d;

    always_comb begin
        rvalid_d = rvalid_q;
        rdata_d  = rdata_q;
        rresp_d  = rresp_q;
        if (s_axi_arvalid && !rvalid_q) begin
            rvalid_d = 1'b1;
            rresp_d  = RESP_OKAY;
            unique case (s_axi_araddr)
                OFF_CONTROL:   rdata_d = byte_word(ctrl_q);
                OFF_MODE:      rdata_d = byte_word({7'h00, down_count_enable_q});
                OFF_COUNT_LO:  rdata_d = byte_word(count_q[7:0]);
                OFF_COUNT_HI:  rdata_d = byte_word(count_q[15:8]);
                OFF_RELOAD_LO: rdata_d = byte_word(reload_q[7:0]);
                OFF_RELOAD_HI: rdata_d = byte_word(reload_q[15:8]);
                OFF_IRQ_EN:    rdata_d = byte_word({7'h00, irq_en_q});
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = RESP_SLVERR;
                end
            endcase
        end else if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else begin
            rvalid_q <= rvalid_d;
            rdata_q  <= rdata_d;
            rresp_q  <= rresp_d;
        end
    end

    assign s_axi_arready = ~rvalid_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
endmodule : t2crc_timer

// *** t2crc_timer_monitor.sv ***
// bus handshake and baud tick checker for the timer
`timescale 1ns/100ps
module t2crc_monitor
    import t2crc_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write channels
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read channels
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // serial ticks
    input wire logic        tx_baud_tick,
    input wire logic        rx_baud_tick
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // ------------------------------------------------------------
    // register bus
    // ------------------------------------------------------------
    chk_write_answer: assert property (
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
        else $error("write response not two cycles after address and data");
    chk_bresp_hold: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before handshake");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after address");
    chk_rdata_hold: assert property (
        s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before handshake");
    chk_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address accepted while data pending");
    chk_err_zero: assert property (
        s_axi_rvalid && s_axi_rresp == RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000)
        else $error("error read returned nonzero data");

    // ------------------------------------------------------------
    // baud ticks come at most every second clock
    // ------------------------------------------------------------
    chk_tx_spacing: assert property (tx_baud_tick |=> !tx_baud_tick)
        else $error("transmit tick on two adjacent cycles");
    chk_rx_spacing: assert property (rx_baud_tick |=> !rx_baud_tick)
        else $error("receive tick on two adjacent cycles");
endmodule : t2crc_monitor

bind t2crc_timer t2crc_monitor i_mon (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .tx_baud_tick(tx_baud_tick), .rx_baud_tick(rx_baud_tick));

// *** t2crc_pin_model.sv ***
// model of the external count and trigger pins
`timescale 1ns/100ps
module t2crc_pin_model (
    // clock
    input wire logic aclk,
    // pins toward the timer
    output logic     count_input,
    output logic     trigger_input
);
    // pins rest high so the first low is a real falling edge
    initial begin
        count_input   = 1'b1;
        trigger_input = 1'b1;
    end

    // each level held four clocks so the sampler cannot miss it
    task automatic pulse_count(input int n);
        repeat (n) begin
            @(posedge aclk);
            count_input <= 1'b0;
            repeat (4) @(posedge aclk);
            count_input <= 1'b1;
            repeat (4) @(posedge aclk);
        end
    endtask : pulse_count

    task automatic set_trigger(input logic lvl);
        @(posedge aclk);
        trigger_input <= lvl;
        repeat (4) @(posedge aclk);
    endtask : set_trigger
endmodule : t2crc_pin_model

// *** t2crc_tb.sv ***
// self-checking testbench of the timer
`timescale 1ns/100ps
module testbench;
    import t2crc_pkg::*;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
    logic        s_axi_arvalid, s_axi_rready, aw_ok, w_ok;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic        count_input, trigger_input, tx_baud_tick, rx_baud_tick, timer_irq;
    int          failures, checked, guard, n_tx, n_rx;

    t2crc_timer i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
        .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
        .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .count_input(count_input),
        .trigger_input(trigger_input), .tx_baud_tick(tx_baud_tick),
        .rx_baud_tick(rx_baud_tick), .timer_irq(timer_irq));
    t2crc_pin_model i_pins (.aclk(aclk), .count_input(count_input),
        .trigger_input(trigger_input));

    // 200 MHz clock
    always #2.5 aclk = ~aclk;

    // ------------------------------------------------------------
    // verdict, compare and bounded wait
    // ------------------------------------------------------------
    task automatic conclude();
        if (failures == 0 && checked > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask : conclude

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp

    task automatic step();
        @(negedge aclk);
        guard++;
        if (guard > 500) begin
            failures++;
            conclude();
        end
    endtask : step

    // ------------------------------------------------------------
    // bus master: ready sampled mid-cycle, signals moved at rising edge
    // ------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1,
                      input logic [1:0] r = RESP_OKAY);
        @(posedge aclk);
        s_axi_awaddr  <= a;
        s_axi_wdata   <= {24'h00_0000, d};
        s_axi_wstrb   <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid  <= 1'b1;
        s_axi_bready  <= 1'b1;
        guard = 0;
        aw_ok = 1'b0;
        w_ok  = 1'b0;
        while (!(aw_ok && w_ok)) begin
            step();
            aw_ok = aw_ok | s_axi_awready;
            w_ok  = w_ok | s_axi_wready;
            @(posedge aclk);
            if (aw_ok) s_axi_awvalid <= 1'b0;
            if (w_ok) s_axi_wvalid <= 1'b0;
        end
        do step(); while (!s_axi_bvalid);
        cmp(32'(s_axi_bresp), 32'(r));
        @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input logic [1:0] resp);
        @(posedge aclk);
        s_axi_araddr  <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready  <= 1'b1;
        guard = 0;
        do step(); while (!s_axi_arready);
        @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        do step(); while (!s_axi_rvalid);
        cmp(s_axi_rdata, 32'(exp));
        cmp(32'(s_axi_rresp), 32'(resp));
        @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask : rd

    task automatic irq_is(input logic e);
        @(negedge aclk);
        cmp(32'(timer_irq), 32'(e));
    endtask : irq_is

    // ticks in forty cycles: a period of two gives twenty
    task automatic ticks(input int e_tx, input int e_rx);
        n_tx = 0;
        n_rx = 0;
        repeat (40) begin
            @(negedge aclk);
            n_tx += int'(tx_baud_tick === 1'b1);
            n_rx += int'(rx_baud_tick === 1'b1);
        end
        cmp(32'(n_tx), 32'(e_tx));
        cmp(32'(n_rx), 32'(e_rx));
    endtask : ticks

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rd(OFF_CONTROL, RST_CONTROL, RESP_OKAY);
        rd(OFF_MODE, 8'h00, RESP_OKAY);
        rd(OFF_COUNT_LO, RST_COUNT[7:0], RESP_OKAY);
        rd(8'h1C, 8'h00, RESP_SLVERR);
        wr(8'h1C, 8'h00, 4'h1, RESP_SLVERR);
    endtask : t_reset

    task automatic t_reload_up();
        wr(OFF_RELOAD_LO, 8'h00);
        wr(OFF_RELOAD_HI, 8'h12);
        wr(OFF_COUNT_LO, 8'hFE);
        wr(OFF_COUNT_HI, 8'hFF);
        wr(OFF_IRQ_EN, 8'h01);
        wr(OFF_CONTROL, 8'h04);
        repeat (30) @(posedge aclk);
        rd(OFF_CONTROL, 8'h84, RESP_OKAY);
        rd(OFF_COUNT_HI, 8'h12, RESP_OKAY);
        irq_is(1'b1);
        wr(OFF_CONTROL, 8'h00);
        irq_is(1'b0);
    endtask : t_reload_up

    task automatic t_trig_reload();
        wr(OFF_RELOAD_HI, 8'h56);
        wr(OFF_CONTROL, 8'h0C);
        i_pins.set_trigger(1'b0);
        i_pins.set_trigger(1'b1);
        rd(OFF_CONTROL, 8'h4C, RESP_OKAY);
        rd(OFF_COUNT_HI, 8'h56, RESP_OKAY);
        wr(OFF_CONTROL, 8'h00);
    endtask : t_trig_reload

    task automatic t_capture();
        wr(OFF_COUNT_LO, 8'h00);
        wr(OFF_COUNT_HI, 8'h34);
        wr(OFF_CONTROL, 8'h05);
        i_pins.set_trigger(1'b0);
        i_pins.set_trigger(1'b1);
        rd(OFF_CONTROL, 8'h05, RESP_OKAY);
        rd(OFF_RELOAD_HI, 8'h56, RESP_OKAY);
        wr(OFF_CONTROL, 8'h0D);
        i_pins.set_trigger(1'b0);
        rd(OFF_CONTROL, 8'h4D, RESP_OKAY);
        rd(OFF_RELOAD_HI, 8'h34, RESP_OKAY);
        rd(OFF_COUNT_HI, 8'h34, RESP_OKAY);
        irq_is(1'b1);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_COUNT_LO, 8'hFF);
        wr(OFF_COUNT_HI, 8'hFF);
        wr(OFF_CONTROL, 8'h05);
        repeat (30) @(posedge aclk);
        rd(OFF_CONTROL, 8'h85, RESP_OKAY);
        rd(OFF_COUNT_HI, 8'h00, RESP_OKAY);
        wr(OFF_CONTROL, 8'h00);
    endtask : t_capture

    task automatic t_updown();
        wr(OFF_MODE, 8'h01);
        wr(OFF_RELOAD_HI, 8'h00);
        wr(OFF_RELOAD_LO, 8'h00);
        wr(OFF_COUNT_LO, 8'h02);
        wr(OFF_COUNT_HI, 8'h00);
        wr(OFF_CONTROL, 8'h04);
        repeat (50) @(posedge aclk);
        rd(OFF_CONTROL, 8'hC4, RESP_OKAY);
        rd(OFF_COUNT_HI, 8'hFF, RESP_OKAY);
        wr(OFF_CONTROL, 8'h44);
        irq_is(1'b0);
        wr(OFF_RELOAD_HI, 8'h77);
        i_pins.set_trigger(1'b1);
        repeat (100) @(posedge aclk);
        rd(OFF_CONTROL, 8'h84, RESP_OKAY);
        rd(OFF_COUNT_HI, 8'h77, RESP_OKAY);
        wr(OFF_CONTROL, 8'h00);
        wr(OFF_MODE, 8'h00);
    endtask : t_updown

    task automatic t_counter();
        wr(OFF_COUNT_LO, 8'h00);
        wr(OFF_COUNT_HI, 8'h00);
        wr(OFF_CONTROL, 8'h06);
        i_pins.pulse_count(3);
        wr(OFF_CONTROL, 8'h00);
        rd(OFF_COUNT_LO, 8'h03, RESP_OKAY);
        wr(OFF_COUNT_LO, 8'h55, 4'h2);
        rd(OFF_COUNT_LO, 8'h03, RESP_OKAY);
    endtask : t_counter

    task automatic t_baud();
        wr(OFF_RELOAD_LO, 8'hFF);
        wr(OFF_RELOAD_HI, 8'hFF);
        wr(OFF_COUNT_LO, 8'hFF);
        wr(OFF_COUNT_HI, 8'hFF);
        wr(OFF_CONTROL, 8'h3C);
        ticks(20, 20);
        i_pins.set_trigger(1'b1);
        i_pins.set_trigger(1'b0);
        rd(OFF_CONTROL, 8'h7C, RESP_OKAY);
        wr(OFF_CONTROL, 8'h14);
        ticks(20, 0);
        wr(OFF_CONTROL, 8'h00);
    endtask : t_baud

    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        aclk          = 1'b0;
        aresetn       = 1'b0;
        s_axi_awvalid = 1'b0;
        s_axi_wvalid  = 1'b0;
        s_axi_bready  = 1'b0;
        s_axi_arvalid = 1'b0;
        s_axi_rready  = 1'b0;
        s_axi_awaddr  = 8'h00;
        s_axi_araddr  = 8'h00;
        s_axi_wdata   = 32'h0000_0000;
        s_axi_wstrb   = 4'h1;
        failures      = 0;
        checked       = 0;
        repeat (20) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_reload_up();
        t_trig_reload();
        t_capture();
        t_updown();
        t_counter();
        t_baud();
        conclude();
    end
endmodule : testbench
